/* sac_pkg.sv */
// Shared constants for the serial attenuator control block
package sac_pkg;
	localparam int FRAME_BITS          = 16;
	localparam int BYTE_BITS           = 8;
	localparam int NUM_CH              = 3;
	localparam int TAP_BITS            = 7;
	localparam logic [7:0] CH1_CODE    = 8'h00;
	localparam logic [7:0] CH2_CODE    = 8'h01;
	localparam logic [7:0] CH3_CODE    = 8'h02;
	localparam logic [7:0] FINE_LAST   = 8'h1f;
	localparam logic [7:0] MID_LAST    = 8'h3f;
	localparam logic [7:0] COARSE_LAST = 8'h4e;
	localparam logic [7:0] MUTE_FIRST  = 8'h4f;
	// Attenuation in half-dB units
	localparam logic [7:0] MID_BASE_HDB    = 8'h20;
	localparam logic [7:0] COARSE_BASE_HDB = 8'h60;
	localparam logic [7:0] MUTE_HDB        = 8'hc8;
	localparam logic [7:0] RESET_CODE      = 8'hff;
	localparam int STROBE_SETUP_NS     = 150;
	localparam int CLK_PERIOD_NS       = 8;
	localparam int STROBE_SETUP_CYC    = (STROBE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		SAC_IDLE  = 2'b01,
		SAC_SHIFT = 2'b10
	} sac_state_t;
endpackage : sac_pkg

/* sac_sync.sv */
// Two-flop synchroniser for one pin input
`timescale 1ns/100ps
module sac_sync
	import sac_pkg::*;
#(
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic sys_clk,
	input  wire logic nrst,
	input  wire logic async_in,
	output logic      sync_out
);
	logic meta_r;

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			meta_r   <= RESET_VAL;
			sync_out <= RESET_VAL;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule : sac_sync

/* sac_ctrl.sv */
// Serial control front end and channel setting latch of the attenuator
`timescale 1ns/100ps
module sac_ctrl
	import sac_pkg::*;
#(
	parameter int FRAME_W = FRAME_BITS
) (
	input  wire logic                sys_clk,
	input  wire logic                nrst,
	input  wire logic                ser_clk,
	input  wire logic                ser_strobe,
	input  wire logic                ser_din,
	output logic                     ser_dout,
	output logic [7:0]               ch1_code,
	output logic [7:0]               ch2_code,
	output logic [7:0]               ch3_code,
	output logic [7:0]               ch1_atten_hdb,
	output logic [7:0]               ch2_atten_hdb,
	output logic [7:0]               ch3_atten_hdb,
	output logic [NUM_CH-1:0]        ch_mute,
	output logic [NUM_CH-1:0]        ch_update,
	output logic [FRAME_W-1:0]       frame_latched
);
	logic       clk_s;
	logic       stb_s;
	logic       din_s;
	logic       clk_d_r;
	logic       stb_d_r;
	sac_state_t state_r;
	sac_state_t state_nxt;
	logic [FRAME_W-1:0] shift_r;
	logic [FRAME_W-1:0] shift_nxt;
	logic       latch_pend_r;

	sac_sync #(.RESET_VAL(1'b0)) u_sync_clk (
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.async_in (ser_clk),
		.sync_out (clk_s)
	);
	sac_sync #(.RESET_VAL(1'b1)) u_sync_stb (
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.async_in (ser_strobe),
		.sync_out (stb_s)
	);
	sac_sync #(.RESET_VAL(1'b0)) u_sync_din (
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.async_in (ser_din),
		.sync_out (din_s)
	);

	// Edge detectors on the synchronised pins; reset values match the idle levels
	wire clk_rise   = clk_s & ~clk_d_r;
	wire stb_rise   = stb_s & ~stb_d_r;
	wire shift_en   = clk_rise & ~stb_s;
	// Only a rise that closes a low period latches
	wire latch_take = stb_rise & (state_r == SAC_SHIFT);
	assign shift_nxt = {shift_r[FRAME_W-2:0], din_s};
	// Chain output is the MSB the register holds once the shift is done
	wire dout_nxt   = shift_nxt[FRAME_W-1];

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			SAC_IDLE:  if (!stb_s) state_nxt = SAC_SHIFT;
			SAC_SHIFT: if (stb_s) state_nxt = SAC_IDLE;
			default:   state_nxt = SAC_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			clk_d_r <= 1'b0;
		end else begin
			clk_d_r <= clk_s;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			stb_d_r <= 1'b1;
		end else begin
			stb_d_r <= stb_s;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			state_r <= SAC_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Shift register moves only on an accepted serial clock rise
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			shift_r <= '0;
		end else if (shift_en) begin
			shift_r <= shift_nxt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ser_dout <= 1'b0;
		end else if (shift_en) begin
			ser_dout <= dout_nxt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			latch_pend_r <= 1'b0;
		end else begin
			latch_pend_r <= latch_take;
		end
	end

	// Holding latch, loaded only on the strobe's rise
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			frame_latched <= {{(FRAME_W-BYTE_BITS){1'b1}}, RESET_CODE};
		end else if (latch_take) begin
			frame_latched <= shift_r;
		end
	end

	wire [7:0] sel_byte  = frame_latched[FRAME_W-1 -: BYTE_BITS];
	wire [7:0] data_byte = frame_latched[BYTE_BITS-1:0];
	wire       sel_ch1   = latch_pend_r & (sel_byte == CH1_CODE);
	wire       sel_ch2   = latch_pend_r & (sel_byte == CH2_CODE);
	wire       sel_ch3   = latch_pend_r & (sel_byte == CH3_CODE);
	// Unknown codes match nothing, so no channel moves
	wire [NUM_CH-1:0] sel_vec = {sel_ch3, sel_ch2, sel_ch1};

	// Step band decode into half-dB units
	wire in_fine   = data_byte <= FINE_LAST;
	wire in_mid    = (data_byte > FINE_LAST) && (data_byte <= MID_LAST);
	wire in_coarse = (data_byte > MID_LAST) && (data_byte <= COARSE_LAST);
	wire is_mute   = data_byte >= MUTE_FIRST;
	wire [7:0] mid_off    = 8'((data_byte - (FINE_LAST + 8'h01)) << 1);
	wire [7:0] coarse_off = 8'((data_byte - (MID_LAST + 8'h01)) << 2);
	wire [7:0] atten_hdb  = in_fine   ? data_byte :
	                        in_mid    ? 8'(MID_BASE_HDB + mid_off) :
	                        in_coarse ? 8'(COARSE_BASE_HDB + coarse_off) :
	                        MUTE_HDB;

	// Mute flags take the new band only for the selected channel
	wire [NUM_CH-1:0] mute_nxt = (sel_vec & {NUM_CH{is_mute}}) | (~sel_vec & ch_mute);

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ch_update <= '0;
		end else begin
			ch_update <= sel_vec;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ch_mute <= '1;
		end else begin
			ch_mute <= mute_nxt;
		end
	end

	// Channel one setting
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ch1_code      <= RESET_CODE;
			ch1_atten_hdb <= MUTE_HDB;
		end else if (sel_ch1) begin
			ch1_code      <= data_byte;
			ch1_atten_hdb <= atten_hdb;
		end
	end

	// Channel two setting
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ch2_code      <= RESET_CODE;
			ch2_atten_hdb <= MUTE_HDB;
		end else if (sel_ch2) begin
			ch2_code      <= data_byte;
			ch2_atten_hdb <= atten_hdb;
		end
	end

	// Channel three setting
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ch3_code      <= RESET_CODE;
			ch3_atten_hdb <= MUTE_HDB;
		end else if (sel_ch3) begin
			ch3_code      <= data_byte;
			ch3_atten_hdb <= atten_hdb;
		end
	end
endmodule : sac_ctrl

/* sac_ctrl_properties.sv */
// Port checks for the serial attenuator control
`timescale 1ns/100ps
module sac_ctrl_properties
	import sac_pkg::*;
#(
	parameter int FRAME_W = FRAME_BITS
) (
	input wire logic               sys_clk,
	input wire logic               nrst,
	input wire logic               ser_strobe,
	input wire logic               ser_dout,
	input wire logic [7:0]         ch1_code,
	input wire logic [7:0]         ch2_code,
	input wire logic [7:0]         ch3_code,
	input wire logic [7:0]         ch1_atten_hdb,
	input wire logic [7:0]         ch2_atten_hdb,
	input wire logic [7:0]         ch3_atten_hdb,
	input wire logic [NUM_CH-1:0]  ch_mute,
	input wire logic [NUM_CH-1:0]  ch_update,
	input wire logic [FRAME_W-1:0] frame_latched
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	sequence strobe_high; ser_strobe [*6]; endsequence
	sequence new_frame; $changed(frame_latched); endsequence
	one_update_a: assert property ($onehot0(ch_update)) else $error("two updates");
	mute_flag_a: assert property (ch_mute[1] == (ch2_code >= MUTE_FIRST)) else $error("mute");
	fine_map_a: assert property (ch1_code <= FINE_LAST |-> ch1_atten_hdb == ch1_code) else $error("fine");
	mid_map_a: assert property (ch2_code inside {[8'h20:8'h3f]} |-> ch2_atten_hdb == 8'(2 * ch2_code - 8'h20)) else $error("mid");
	coarse_map_a: assert property (ch3_code inside {[8'h40:8'h4e]} |-> ch3_atten_hdb == 8'(4 * ch3_code - 8'ha0)) else $error("coarse");
	keep_ch_a: assert property (!ch_update[2] |-> $stable(ch3_code)) else $error("kept");
	sel_ch_a: assert property (ch_update[1] |-> frame_latched[15:8] == CH2_CODE && ch2_code == frame_latched[7:0]) else $error("sel");
	apply_frame_a: assert property (new_frame ##0 frame_latched[15:8] <= CH3_CODE |=> |ch_update) else $error("apply");
	bad_sel_a: assert property (frame_latched[15:8] > CH3_CODE |-> ch_update == 3'b000) else $error("bad sel");
	latch_rise_a: assert property (new_frame |-> $past(ser_strobe, 3)) else $error("latch");
	dout_idle_a: assert property (strobe_high |=> $stable(ser_dout)) else $error("dout");
endmodule : sac_ctrl_properties
bind sac_ctrl sac_ctrl_properties #(.FRAME_W(FRAME_W)) sac_ctrl_properties_inst (.*);

/* sac_host.sv */
// Host model driving the three-wire serial control pins
`timescale 1ns/100ps
module sac_host (
	output logic      ser_clk,
	output logic      ser_strobe,
	output logic      ser_din,
	input  wire logic ser_dout
);
	logic [15:0] out_r = 16'h0;
	initial begin
		ser_clk = 1'b0;
		ser_strobe = 1'b1;
		ser_din = 1'b0;
	end
	task automatic send(input logic [31:0] bits, input int n, input logic en);
		ser_strobe = !en;
		#200;
		for (int i = n - 1; i >= 0; i--) begin
			ser_din = bits[i];
			#80;
			// A downstream device takes the pin just before its rising edge
			out_r = {out_r[14:0], ser_dout};
			ser_clk = 1'b1;
			#80 ser_clk = 1'b0;
		end
		ser_din = !ser_din;
		#200 ser_strobe = 1'b1;
		#400;
	endtask : send
endmodule : sac_host

/* sac_ctrl_bench.sv */
// Self-checking bench for the serial attenuator control
`timescale 1ns/100ps
module sac_ctrl_bench;
	import sac_pkg::*;
	logic        sys_clk = 0, nrst = 0, ser_clk, ser_strobe, ser_din, ser_dout;
	logic [7:0]  ch1_code, ch2_code, ch3_code, ch1_atten_hdb, ch2_atten_hdb, ch3_atten_hdb;
	logic [2:0]  ch_mute, ch_update;
	logic [15:0] frame_latched, exp_f = 16'hffff;
	logic [7:0]  exp_c [3] = '{3{8'hff}};
	int          num_errors = 0, check_count = 0, exp_upd = 0, upd_seen = 0;
	logic [15:0] exp_sh = 16'h0;
	always #4 sys_clk = ~sys_clk;
	always @(negedge sys_clk) upd_seen += $countones(ch_update);
	sac_ctrl sac_ctrl_inst (.sys_clk, .nrst, .ser_clk, .ser_strobe, .ser_din, .ser_dout,
		.ch1_code, .ch2_code, .ch3_code, .ch1_atten_hdb, .ch2_atten_hdb, .ch3_atten_hdb,
		.ch_mute, .ch_update, .frame_latched);
	sac_host sac_host_inst (.ser_clk, .ser_strobe, .ser_din, .ser_dout);
	function automatic logic [7:0] hdb(input logic [7:0] c);
		if (c <= 8'h1f) return c;
		if (c <= 8'h3f) return 2 * c - 8'h20;
		if (c <= 8'h4e) return 4 * c - 8'ha0;
		return 8'hc8;
	endfunction : hdb
	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : finish_test
	task automatic check(input string nm, input logic [15:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic verify();
		logic [7:0] s [6];
		s = '{ch1_code, ch2_code, ch3_code, ch1_atten_hdb, ch2_atten_hdb, ch3_atten_hdb};
		check("frame", frame_latched, exp_f);
		for (int i = 0; i < 3; i++) begin
			check("code", s[i], exp_c[i]);
			check("atten", s[i + 3], hdb(exp_c[i]));
			check("mute", ch_mute[i], exp_c[i] >= MUTE_FIRST);
		end
		check("updates", 16'(upd_seen), 16'(exp_upd));
	endtask : verify
	task automatic frame(input logic [31:0] b, input int n, input logic en);
		logic [15:0] exp_d;
		exp_d = (n == 16) ? exp_sh : b[31:16];
		sac_host_inst.send(b, n, en);
		if (en) check("dout", sac_host_inst.out_r, exp_d);
		if (en) exp_f = b[15:0];
		if (en) exp_sh = b[15:0];
		if (en && exp_f[15:8] < 8'h03) exp_c[exp_f[15:8]] = exp_f[7:0];
		if (en && exp_f[15:8] < 8'h03) exp_upd++;
		verify();
	endtask : frame
	initial begin
		#400000;
		num_errors++;
		finish_test();
	end
	initial begin
		logic [7:0] dv [8] = '{8'h00, 8'h1f, 8'h20, 8'h3f, 8'h40, 8'h4e, 8'h4f, 8'hff};
		void'($urandom(32'h078f2d33));
		repeat (20) @(negedge sys_clk);
		nrst = 1'b1;
		repeat (3) @(negedge sys_clk);
		verify();
		$display("reset test done");
		for (int i = 0; i < 32; i++) frame({22'h0, i[1:0], dv[(i / 4) % 8]}, 16, 1'b1);
		$display("code table test done");
		repeat (16) frame({22'h0, 2'($urandom % 4), 8'($urandom)}, 16, 1'b1);
		$display("random test done");
		frame(32'h0000_0033, 16, 1'b0);
		$display("disabled test done");
		frame(32'h0211_0122, 32, 1'b1);
		check("dout", sac_host_inst.out_r, 16'h0211);
		$display("chain test done");
		finish_test();
	end
endmodule : sac_ctrl_bench
